/* hw/txfq_pkg.sv */
// Purpose: shared constants and field layouts for the transmit fifo/queue status block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes:   one aligned word per register
package txfq_pkg;

    localparam int unsigned  NUM_BUFFERS   = 32;
    localparam logic [11:0]  ADDR_STATUS   = 12'h0c4;
    localparam logic [11:0]  ADDR_CONFIG   = 12'h100;
    localparam logic [11:0]  ADDR_IRQ_STAT = 12'h104;
    localparam logic [11:0]  ADDR_IRQ_MASK = 12'h108;

    localparam logic [31:0]  STATUS_RESET  = 32'h0000_0000;
    localparam logic [31:0]  CONFIG_RESET  = 32'h0000_0000;
    localparam logic [1:0]   IRQ_RESET     = 2'h0;

    localparam int unsigned  IRQ_FULL_BIT  = 0;
    localparam int unsigned  IRQ_EMPTY_BIT = 1;

    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_SLVERR   = 2'h2;

    // status word: full flag bit 21, put index 20:16, get index 12:8, free level 5:0
    typedef struct packed {
        logic [9:0] rsvd_hi;
        logic       fifo_queue_full_flag;
        logic [4:0] fifo_queue_put_index;
        logic [2:0] rsvd_mid;
        logic [4:0] fifo_get_index;
        logic [1:0] rsvd_lo;
        logic [5:0] fifo_free_level;
    } status_s;

    // transmit buffer configuration word
    typedef struct packed {
        logic       rsvd_top;
        logic       queue_mode_select;
        logic [5:0] fifo_queue_size;
        logic [1:0] rsvd_a;
        logic [5:0] dedicated_count;
        logic [15:0] rsvd_b;
    } tx_buffer_configuration_s;

    typedef struct packed {
        logic [11:0] addr;
        logic        held;
    } addr_hold_s;

endpackage : txfq_pkg

/* hw/txfq_status_calc.sv */
// Purpose: combinational derivation of fifo/queue status from the pending request vector
// Assumes: buffers numbered 0..31, dedicated buffers first, fifo/queue region after them
// Notes:   region is clamped so it never runs past buffer 31
`timescale 1ns/1ps
module txfq_status_calc
(
    input  wire logic [31:0]                       pending,
    input  wire txfq_pkg::tx_buffer_configuration_s cfg,
    input  wire logic [4:0]                        prev_get,
    output txfq_pkg::status_s                      status
);
    int          base;
    int          lim;
    int          cnt;
    int          start_off;
    int          free_off;
    int          pred;
    logic        start_found;
    logic        free_found;
    logic [4:0]  hold_get;

    always_comb
    begin
        base        = int'(cfg.dedicated_count);
        lim         = int'(cfg.fifo_queue_size);
        cnt         = 0;
        start_off   = 0;
        free_off    = 0;
        pred        = 0;
        start_found = 1'b0;
        free_found  = 1'b0;
        if (base >= 32)
            lim = 0;
        else if (base + lim > 32)
            lim = 32 - base;
        // region membership always taken from the pending vector, never from software requests
        for (int i = 0; i < 32; i++)
        begin
            if (i < lim)
            begin
                pred = (i == 0) ? lim - 1 : i - 1;
                if (pending[base + i])
                    cnt = cnt + 1;
                if (pending[base + i] && !pending[base + pred] && !start_found)
                begin
                    start_found = 1'b1;
                    start_off   = i;
                end
                if (!pending[base + i] && !free_found)
                begin
                    free_found = 1'b1;
                    free_off   = i;
                end
            end
        end
        // an empty or full fifo has no run start; keep the last get index if it lies in the region
        if (int'(prev_get) >= base && int'(prev_get) < base + lim)
            hold_get = prev_get;
        else
            hold_get = 5'(base);

        status                      = txfq_pkg::STATUS_RESET;
        status.fifo_free_level      = 6'(lim - cnt);
        status.fifo_queue_full_flag = (lim == cnt);
        if (cfg.queue_mode_select)
        begin
            status.fifo_get_index       = 5'h00;
            status.fifo_queue_put_index = 5'(base + free_off);
        end
        else if (cnt == 0 || cnt == lim)
        begin
            status.fifo_get_index       = hold_get;
            status.fifo_queue_put_index = hold_get;
        end
        else
        begin
            status.fifo_get_index       = 5'(base + start_off);
            status.fifo_queue_put_index = 5'(base + ((start_off + cnt) % lim));
        end
    end

endmodule : txfq_status_calc

/* hw/can_tx_fifo_queue_status.sv */
// Purpose: read-only transmit fifo/queue status register with axi4-lite access and interrupt
// Assumes: pending request vector comes from logic on ref_clk, so it is not synchronised
// Notes:   status is re-registered every cycle; a read returns the value of the previous cycle
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module can_tx_fifo_queue_status
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [31:0] pending_tx_request_register,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[8*b +: 8] = new_v[8*b +: 8];
        return res;
    endfunction : merge_bytes

    function automatic logic mapped(input logic [11:0] a);
        return a == txfq_pkg::ADDR_STATUS || a == txfq_pkg::ADDR_CONFIG ||
               a == txfq_pkg::ADDR_IRQ_STAT || a == txfq_pkg::ADDR_IRQ_MASK;
    endfunction : mapped

    txfq_pkg::status_s                  status_q;
    txfq_pkg::status_s                  status_d;
    txfq_pkg::tx_buffer_configuration_s cfg_q;
    txfq_pkg::tx_buffer_configuration_s cfg_d;
    txfq_pkg::addr_hold_s               aw_q;
    logic [31:0]                        wdata_q;
    logic [3:0]                         wstrb_q;
    logic                               w_held_q;
    logic [1:0]                         irq_stat_q;
    logic [1:0]                         irq_stat_d;
    logic [1:0]                         irq_mask_q;
    logic [1:0]                         irq_mask_d;
    logic                               awready_q;
    logic                               wready_q;
    logic                               bvalid_q;
    logic [1:0]                         bresp_q;
    logic                               arready_q;
    logic                               rvalid_q;
    logic [31:0]                        rdata_q;
    logic [1:0]                         rresp_q;
    logic                               irq_q;

    // combinational decode
    wire         aw_take    = s_axi_awvalid && awready_q;
    wire         w_take     = s_axi_wvalid && wready_q;
    wire         ar_take    = s_axi_arvalid && arready_q;
    wire         do_write   = aw_q.held && w_held_q && !bvalid_q;
    wire         wr_cfg     = do_write && aw_q.addr == txfq_pkg::ADDR_CONFIG;
    wire         wr_istat   = do_write && aw_q.addr == txfq_pkg::ADDR_IRQ_STAT;
    wire         wr_imask   = do_write && aw_q.addr == txfq_pkg::ADDR_IRQ_MASK;
    wire  [11:0] rd_addr    = s_axi_araddr[11:0];
    wire         rd_hit     = mapped(rd_addr) && s_axi_araddr[31:12] == 20'h00000;
    wire  [31:0] wr_merged  = merge_bytes(32'h0000_0000, wdata_q, wstrb_q);
    wire  [1:0]  irq_clr    = wr_istat ? wr_merged[1:0] : 2'h0;
    // a refused read returns zero, even where the low address bits name a register
    wire  [31:0] rd_value   = !rd_hit                              ? 32'h0000_0000 :
                              (rd_addr == txfq_pkg::ADDR_STATUS)   ? status_q :
                              (rd_addr == txfq_pkg::ADDR_CONFIG)   ? cfg_q :
                              (rd_addr == txfq_pkg::ADDR_IRQ_STAT) ? {30'h0, irq_stat_q} :
                              (rd_addr == txfq_pkg::ADDR_IRQ_MASK) ? {30'h0, irq_mask_q} :
                              32'h0000_0000;

    // events: the fifo/queue turning full, and the free level rising to the configured fifo_queue_size (never when the region is clamped)
    wire         ev_full    = status_d.fifo_queue_full_flag && !status_q.fifo_queue_full_flag;
    wire         ev_empty   = status_d.fifo_free_level == cfg_q.fifo_queue_size &&
                              status_q.fifo_free_level != cfg_q.fifo_queue_size &&
                              cfg_q.fifo_queue_size != 6'h00;
    wire  [1:0]  irq_ev     = {ev_empty, ev_full};

    // a new event in the clearing cycle survives the clear
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
    assign irq_mask_d = wr_imask ? 2'(merge_bytes({30'h0, irq_mask_q}, wdata_q, wstrb_q)) : irq_mask_q;
    assign cfg_d      = wr_cfg ? merge_bytes(cfg_q, wdata_q, wstrb_q) : cfg_q;

    // status is a function of the pending vector, the configuration and the registered get index
    txfq_status_calc u_calc
    (
        .pending  (pending_tx_request_register),
        .cfg      (cfg_q),
        .prev_get (status_q.fifo_get_index),
        .status   (status_d)
    );

    // all four status fields load in the same edge, so they never disagree
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            status_q <= txfq_pkg::STATUS_RESET;
        else
            status_q <= status_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_q      <= txfq_pkg::CONFIG_RESET;
            irq_stat_q <= txfq_pkg::IRQ_RESET;
            irq_mask_q <= txfq_pkg::IRQ_RESET;
            irq_q      <= 1'b0;
        end
        else
        begin
            cfg_q      <= cfg_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d[1:0];
            irq_q      <= |(irq_stat_d & irq_mask_d[1:0]);
        end
    end

    // write address and data are taken independently and may arrive in either order
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            aw_q      <= '0;
            awready_q <= 1'b0;
        end
        else if (aw_take)
        begin
            // only the low twelve bits decode on a write
            aw_q      <= '{addr: s_axi_awaddr[11:0], held: 1'b1};
            awready_q <= 1'b0;
        end
        else if (do_write)
            aw_q.held <= 1'b0;
        else if (!aw_q.held && !bvalid_q)
            awready_q <= 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            w_held_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else if (w_take)
        begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
        end
        else if (do_write)
            w_held_q <= 1'b0;
        else if (!w_held_q && !bvalid_q)
            wready_q <= 1'b1;
    end

    // the status register is read-only: a write to it is accepted and dropped
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= txfq_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(aw_q.addr) ? txfq_pkg::RESP_OKAY : txfq_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= txfq_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_value;
            rresp_q   <= rd_hit ? txfq_pkg::RESP_OKAY : txfq_pkg::RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q  <= 1'b0;
        else if (!rvalid_q)
            arready_q <= 1'b1;
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign irq           = irq_q;

endmodule : can_tx_fifo_queue_status

/* tb/can_tx_fifo_queue_status_assertions.sv */
// Purpose: bus timing and status word checks for the fifo/queue status block
// Assumes: single clock domain, srst synchronous active high
// Notes:   status reads are recognised by the captured read address
`timescale 1ns/1ps
module can_tx_fifo_queue_status_assertions
(
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [31:0] rd_addr_q;
    logic        st_rd;
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rd_addr_q <= 32'h0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr_q <= s_axi_araddr;
    end
    // a status word is judged only while an okay answer for 0xc4 is held
    assign st_rd = s_axi_rvalid && (rd_addr_q == {20'h0, txfq_pkg::ADDR_STATUS}) &&
                   (s_axi_rresp == txfq_pkg::RESP_OKAY);
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_answer;
        s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rd_refuse;
        s_rd_take ##0 (s_axi_araddr[31:12] != 20'h0) |=>
            s_axi_rresp == txfq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_full_free;
        st_rd |-> s_axi_rdata[21] == (s_axi_rdata[5:0] == 6'h00);
    endproperty
    property p_reserved;
        st_rd |-> s_axi_rdata[31:22] == 10'h0 && s_axi_rdata[15:13] == 3'h0 && s_axi_rdata[7:6] == 2'h0;
    endproperty
    property p_free_max;
        st_rd |-> s_axi_rdata[5:0] <= 6'h20;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer not one edge after acceptance");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before rready");
    a_wr_answer: assert property (p_wr_answer) else $error("write response not two edges after acceptance");
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped before bready");
    a_rd_refuse: assert property (p_rd_refuse) else $error("unmapped read not refused");
    a_full_free: assert property (p_full_free) else $error("full flag disagrees with free level");
    a_reserved: assert property (p_reserved) else $error("status field outside its bits");
    a_free_max: assert property (p_free_max) else $error("free level above buffer count");
endmodule : can_tx_fifo_queue_status_assertions

/* tb/can_tx_fifo_queue_status_tb_top.sv */
// Purpose: self-checking bench for the fifo/queue status block
// Assumes: axi4-lite master driven on ref_clk rising edges
// Notes:   pending vector driven directly; no transmit scan behind it
`timescale 1ns/1ps
module can_tx_fifo_queue_status_tb_top;
    localparam logic [31:0] A_ST = {20'h0, txfq_pkg::ADDR_STATUS};
    localparam logic [31:0] A_CF = {20'h0, txfq_pkg::ADDR_CONFIG};
    localparam logic [31:0] A_IS = {20'h0, txfq_pkg::ADDR_IRQ_STAT};
    localparam logic [31:0] A_IM = {20'h0, txfq_pkg::ADDR_IRQ_MASK};
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [31:0] pending_tx_request_register = 32'h0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int          fails = 0;
    int          n_tests = 0;
    int          cycles = 0;
    can_tx_fifo_queue_status can_tx_fifo_queue_status_inst
    (
        .ref_clk                     (ref_clk),
        .srst                        (srst),
        .pending_tx_request_register (pending_tx_request_register),
        .s_axi_awaddr                (s_axi_awaddr),
        .s_axi_awvalid               (s_axi_awvalid),
        .s_axi_awready               (s_axi_awready),
        .s_axi_wdata                 (s_axi_wdata),
        .s_axi_wstrb                 (s_axi_wstrb),
        .s_axi_wvalid                (s_axi_wvalid),
        .s_axi_wready                (s_axi_wready),
        .s_axi_bresp                 (s_axi_bresp),
        .s_axi_bvalid                (s_axi_bvalid),
        .s_axi_bready                (s_axi_bready),
        .s_axi_araddr                (s_axi_araddr),
        .s_axi_arvalid               (s_axi_arvalid),
        .s_axi_arready               (s_axi_arready),
        .s_axi_rdata                 (s_axi_rdata),
        .s_axi_rresp                 (s_axi_rresp),
        .s_axi_rvalid                (s_axi_rvalid),
        .s_axi_rready                (s_axi_rready),
        .irq                         (irq)
    );
    always #2 ref_clk = ~ref_clk;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // a hang counts as a mismatch and still reaches the one verdict
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 50) fails++;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 50) fails++;
    endtask : rd
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, txfq_pkg::RESP_OKAY});
    endtask : rchk
    task automatic wchk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask : wchk
    task automatic pend(input logic [31:0] v);
        @(posedge ref_clk);
        pending_tx_request_register <= v;
        repeat (2) @(posedge ref_clk);
    endtask : pend
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_is
    task automatic t_reset();
        rchk(A_ST, 32'h0020_0000);
        rchk(A_CF, 32'h0);
        rchk(A_IS, 32'h1);
        rchk(A_IM, 32'h0);
        irq_is(1'b0);
    endtask : t_reset
    task automatic t_fifo();
        wchk(A_CF, 32'h140c_0000, txfq_pkg::RESP_OKAY);
        pend(32'h0000_7000);
        rchk(A_ST, 32'h000f_0c11);
        pend(32'h0007_8000);
        rchk(A_ST, 32'h0013_0f10);
        pend(32'hc000_1000);
        rchk(A_ST, 32'h000d_1e11);
    endtask : t_fifo
    task automatic t_irq();
        wchk(A_IS, 32'h3, txfq_pkg::RESP_OKAY);
        pend(32'hffff_f000);
        rchk(A_ST, 32'h003e_1e00);
        rchk(A_IS, 32'h1);
        irq_is(1'b0);
        wchk(A_IM, 32'h1, txfq_pkg::RESP_OKAY);
        irq_is(1'b1);
        wchk(A_IS, 32'h1, txfq_pkg::RESP_OKAY);
        irq_is(1'b0);
        pend(32'h0);
        rchk(A_IS, 32'h2);
        irq_is(1'b0);
        wchk(A_IM, 32'h3, txfq_pkg::RESP_OKAY);
        irq_is(1'b1);
        wchk(A_IS, 32'h2, txfq_pkg::RESP_OKAY);
        irq_is(1'b0);
    endtask : t_irq
    task automatic t_queue();
        wchk(A_CF, 32'h540c_0000, txfq_pkg::RESP_OKAY);
        pend(32'h0000_3000);
        rchk(A_ST, 32'h000e_0012);
        rchk(A_CF, 32'h540c_0000);
    endtask : t_queue
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0]  r;
        rd(32'h0000_0200, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, txfq_pkg::RESP_SLVERR});
        rd(32'h1000_00c4, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, txfq_pkg::RESP_SLVERR});
        wchk(32'h0000_0200, 32'h1, txfq_pkg::RESP_SLVERR);
        // status is read-only: the write is accepted but changes nothing
        wchk(A_ST, 32'hffff_ffff, txfq_pkg::RESP_OKAY);
        rchk(A_ST, 32'h000e_0012);
    endtask : t_bus
    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_fifo();
        t_irq();
        t_queue();
        t_bus();
        conclude();
    end
endmodule : can_tx_fifo_queue_status_tb_top
bind can_tx_fifo_queue_status can_tx_fifo_queue_status_assertions can_tx_fifo_queue_status_assertions_inst
(
    .ref_clk       (ref_clk),
    .srst          (srst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
);
